// File: rtl/fcb_pkg.sv
package fcb_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int FCB_PC_W  = 16;
	localparam int FCB_OFS_W = 7;

	// ----------------------------------------
	// Reset values and step sizes
	// ----------------------------------------
	localparam logic [FCB_PC_W-1:0] FCB_PC_RESET = 16'h0000;
	localparam logic [FCB_PC_W-1:0] FCB_PC_STEP  = 16'h0001;

	// Branch condition selector, one code per conditional opcode
	typedef enum logic [3:0] {
		FCB_JUMP_IF_LOWER,
		FCB_JUMP_IF_NEGATIVE,
		FCB_JUMP_IF_POSITIVE,
		FCB_JUMP_IF_SIGNED_GE,
		FCB_JUMP_IF_SIGNED_LT,
		FCB_JUMP_IF_NIBBLE_CARRY,
		FCB_JUMP_IF_NO_NIBBLE_CARRY,
		FCB_JUMP_IF_SPARE_SET,
		FCB_JUMP_IF_SPARE_CLEAR,
		FCB_JUMP_IF_WRAP_SET,
		FCB_JUMP_IF_NO_BORROW,
		FCB_JUMP_IF_SAME_OR_ABOVE
	} fcb_cond_t;

	// Execution phases
	typedef enum logic [0:0] {
		FCB_ST_IDLE,
		FCB_ST_RELOAD
	} fcb_state_t;

endpackage

// File: rtl/fcb_branch_unit.sv
`timescale 1ns/1ns
// Functional notes
// - Lower branch is taken when borrow bit is one, else falls through.
// - Negative branch is taken only when msb result bit is one.
// - Positive branch is taken only when msb result bit is zero.
// - Signed greater-or-equal taken when msb xor wrap is zero.
// - Signed less-than taken when msb xor wrap is one.
// - Nibble-carry branch taken when low nibble carry is one.
// - No-nibble-carry branch taken when low nibble carry is zero.
// - Spare-set branch taken when spare flag is one.
// - Spare-clear branch taken when spare flag is zero.
// - Wrap-set branch taken when signed wrap bit is one.
// - Taken branch loads PC plus offset plus one; flags untouched; two clocks.
// - No-borrow and same-or-above branches taken when borrow bit is zero.
module fcb_branch_unit
	import fcb_pkg::*;
#(
	parameter int PC_W  = FCB_PC_W,
	parameter int OFS_W = FCB_OFS_W
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_clk_en,
	input  wire logic             i_start,
	input  wire fcb_cond_t        i_cond,
	input  wire logic [OFS_W-1:0] i_jump_offset,
	input  wire logic [PC_W-1:0]  i_pc,
	input  wire logic             i_borrow_bit,
	input  wire logic             i_msb_result_bit,
	input  wire logic             i_signed_wrap_bit,
	input  wire logic             i_low_nibble_carry,
	input  wire logic             i_spare_flag_bool,
	output logic                  o_busy,
	output logic                  o_done,
	output logic                  o_taken,
	output logic [PC_W-1:0]       o_next_pc
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		fcb_state_t      state;
		logic            done;
		logic            taken;
		logic [PC_W-1:0] next_pc;
		logic [PC_W-1:0] target;
	} fcb_regs_t;

	fcb_regs_t regs_r;
	fcb_regs_t regs_nxt;
	logic      cond_met;
	logic [PC_W-1:0] target_pc;

	// ----------------------------------------
	// Target address
	// ----------------------------------------
	// Sign-extend the offset so backward branches work
	// the sum wraps at the PC width just as the core's own counter does
	assign target_pc = PC_W'(i_pc + PC_W'($signed(i_jump_offset)) + FCB_PC_STEP);

	// ----------------------------------------
	// Condition decode and sequencer
	// ----------------------------------------
	// Flags are only read, never written; the block has no flag outputs
	always_comb begin
		case (i_cond)
			FCB_JUMP_IF_LOWER:           cond_met = i_borrow_bit;
			FCB_JUMP_IF_NEGATIVE:        cond_met = i_msb_result_bit;
			FCB_JUMP_IF_POSITIVE:        cond_met = !i_msb_result_bit;
			FCB_JUMP_IF_SIGNED_GE:       cond_met = !(i_msb_result_bit ^ i_signed_wrap_bit);
			FCB_JUMP_IF_SIGNED_LT:       cond_met = i_msb_result_bit ^ i_signed_wrap_bit;
			FCB_JUMP_IF_NIBBLE_CARRY:    cond_met = i_low_nibble_carry;
			FCB_JUMP_IF_NO_NIBBLE_CARRY: cond_met = !i_low_nibble_carry;
			FCB_JUMP_IF_SPARE_SET:       cond_met = i_spare_flag_bool;
			FCB_JUMP_IF_SPARE_CLEAR:     cond_met = !i_spare_flag_bool;
			FCB_JUMP_IF_WRAP_SET:        cond_met = i_signed_wrap_bit;
			FCB_JUMP_IF_NO_BORROW,
			FCB_JUMP_IF_SAME_OR_ABOVE:   cond_met = !i_borrow_bit;
			default:                     cond_met = 1'h0;
		endcase

		// Next state: fall through in one clock, reload in two
		// start is only looked at in idle, so a request while busy is dropped
		regs_nxt      = regs_r;
		regs_nxt.done = 1'h0;
		case (regs_r.state)
			FCB_ST_IDLE: begin
				if (i_start) begin
					if (cond_met) begin
						regs_nxt.state  = FCB_ST_RELOAD;
						regs_nxt.target = target_pc;
					end else begin
						regs_nxt.done    = 1'h1;
						regs_nxt.taken   = 1'h0;
						regs_nxt.next_pc = PC_W'(i_pc + FCB_PC_STEP);
					end
				end
			end
			FCB_ST_RELOAD: begin
				regs_nxt.state   = FCB_ST_IDLE;
				regs_nxt.done    = 1'h1;
				regs_nxt.taken   = 1'h1;
				regs_nxt.next_pc = regs_r.target;
			end
			default: regs_nxt.state = FCB_ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Register stage
	// ----------------------------------------
	// Clock enable low freezes everything, a pending reload included
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			regs_r.state   <= FCB_ST_IDLE;
			regs_r.done    <= 1'h0;
			regs_r.taken   <= 1'h0;
			regs_r.next_pc <= FCB_PC_RESET;
			regs_r.target  <= FCB_PC_RESET;
		end else if (i_clk_en) begin
			regs_r <= regs_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Busy is a plain decode of the state; result outputs come straight from flops
	assign o_busy    = (regs_r.state == FCB_ST_RELOAD);
	assign o_done    = regs_r.done;
	assign o_taken   = regs_r.taken;
	assign o_next_pc = regs_r.next_pc;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_taken_req;
		i_clk_en && i_start && !o_busy && cond_met;
	endsequence

	sequence s_fall_req;
		i_clk_en && i_start && !o_busy && !cond_met;
	endsequence

	AST_TWO_CLOCKS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_taken_req ##1 i_clk_en |=> o_done && o_taken)
		else $error("taken branch did not finish in two clocks");

	AST_ONE_CLOCK: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_fall_req |=> o_done && !o_taken && o_next_pc == PC_W'($past(i_pc) + FCB_PC_STEP))
		else $error("untaken branch did not fall through in one clock");

	AST_TARGET: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_taken_req ##1 i_clk_en |=> o_next_pc == PC_W'($past(i_pc, 2)
			+ PC_W'($signed($past(i_jump_offset, 2))) + FCB_PC_STEP))
		else $error("taken target is not pc plus offset plus one");

	AST_LOWER: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_cond == FCB_JUMP_IF_LOWER |-> cond_met == i_borrow_bit)
		else $error("lower branch condition wrong");

	AST_NO_BORROW: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_cond == FCB_JUMP_IF_NO_BORROW || i_cond == FCB_JUMP_IF_SAME_OR_ABOVE) |-> cond_met != i_borrow_bit)
		else $error("no-borrow branch condition wrong");

	AST_NEG_POS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_cond == FCB_JUMP_IF_NEGATIVE |-> cond_met == i_msb_result_bit)
		and (i_cond == FCB_JUMP_IF_POSITIVE |-> cond_met != i_msb_result_bit))
		else $error("sign branch condition wrong");

	AST_SIGNED: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_cond == FCB_JUMP_IF_SIGNED_LT |-> cond_met == (i_msb_result_bit ^ i_signed_wrap_bit))
		and (i_cond == FCB_JUMP_IF_SIGNED_GE |-> cond_met != (i_msb_result_bit ^ i_signed_wrap_bit)))
		else $error("signed compare branch condition wrong");

	AST_NIBBLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_cond == FCB_JUMP_IF_NIBBLE_CARRY |-> cond_met == i_low_nibble_carry)
		and (i_cond == FCB_JUMP_IF_NO_NIBBLE_CARRY |-> cond_met != i_low_nibble_carry))
		else $error("nibble carry branch condition wrong");

	AST_SPARE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_cond == FCB_JUMP_IF_SPARE_SET |-> cond_met == i_spare_flag_bool)
		and (i_cond == FCB_JUMP_IF_SPARE_CLEAR |-> cond_met != i_spare_flag_bool))
		else $error("spare flag branch condition wrong");

	AST_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_cond == FCB_JUMP_IF_WRAP_SET |-> cond_met == i_signed_wrap_bit)
		else $error("wrap branch condition wrong");

	// Far enough from address zero, a negative offset never lands above the start
	AST_BACKWARD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(s_taken_req and (i_jump_offset[OFS_W-1] && i_pc > PC_W'(OFS_W'(1) << (OFS_W-1))))
		##1 i_clk_en |=> o_next_pc <= PC_W'($past(i_pc, 2)))
		else $error("negative offset did not branch backward");

	// One enabled clock spent in the reload state
	sequence s_reload_step;
		i_clk_en && o_busy;
	endsequence

	AST_BUSY_ONE_CYCLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_reload_step |=> !o_busy && o_done && o_taken)
		else $error("reload state did not end after one enabled clock");

	AST_TAKEN_BUSY: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_taken_req |=> o_busy && !o_done)
		else $error("taken branch did not enter the reload clock");

	AST_FALL_NOT_BUSY: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_fall_req |=> !o_busy)
		else $error("untaken branch raised busy");

	AST_IDLE_QUIET: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_clk_en && !i_start && !o_busy |=> !o_done)
		else $error("done raised with no request");

	AST_FREEZE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!i_clk_en |=> $stable(o_busy) && $stable(o_done) && $stable(o_taken) && $stable(o_next_pc))
		else $error("state moved while the clock enable was low");

	AST_RESULT_HELD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!o_done ##1 !o_done |-> $stable(o_next_pc) && $stable(o_taken))
		else $error("result changed without a done pulse");

endmodule

// File: tb/fcb_testbench.sv
`timescale 1ns/1ns
module testbench
	import fcb_pkg::*;
;
	logic        i_sys_clk     = 1'h0;
	logic        i_reset_n     = 1'h0;
	logic        i_clk_en      = 1'h1;
	logic        i_start       = 1'h0;
	fcb_cond_t   i_cond        = FCB_JUMP_IF_LOWER;
	logic [6:0]  i_jump_offset = 7'h00;
	logic [15:0] i_pc          = 16'h0000;
	logic [4:0]  flg           = 5'h00;
	logic        o_busy;
	logic        o_done;
	logic        o_taken;
	logic [15:0] o_next_pc;
	int          bad_count     = 0;
	int          checked       = 0;
	logic [4:0]  pats [3]      = '{5'h00, 5'h1F, 5'h0A};

	// ----------------------------------------
	// Clock and unit under test
	// ----------------------------------------
	always #10 i_sys_clk = ~i_sys_clk;

	// Flag vector order: borrow, msb, wrap, nibble carry, spare
	fcb_branch_unit dut_u (
		.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_start(i_start),
		.i_cond(i_cond), .i_jump_offset(i_jump_offset), .i_pc(i_pc), .i_borrow_bit(flg[4]),
		.i_msb_result_bit(flg[3]), .i_signed_wrap_bit(flg[2]), .i_low_nibble_carry(flg[1]),
		.i_spare_flag_bool(flg[0]), .o_busy(o_busy), .o_done(o_done), .o_taken(o_taken),
		.o_next_pc(o_next_pc)
	);

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t mismatch got %h expected %h", $time, seen, exp);
		end
	endtask

	// Branch decision worked out independently of the design
	function automatic logic exp_take(input fcb_cond_t c, input logic [4:0] f);
		case (c)
			FCB_JUMP_IF_LOWER:           return f[4];
			FCB_JUMP_IF_NEGATIVE:        return f[3];
			FCB_JUMP_IF_POSITIVE:        return !f[3];
			FCB_JUMP_IF_SIGNED_GE:       return !(f[3] ^ f[2]);
			FCB_JUMP_IF_SIGNED_LT:       return f[3] ^ f[2];
			FCB_JUMP_IF_NIBBLE_CARRY:    return f[1];
			FCB_JUMP_IF_NO_NIBBLE_CARRY: return !f[1];
			FCB_JUMP_IF_SPARE_SET:       return f[0];
			FCB_JUMP_IF_SPARE_CLEAR:     return !f[0];
			FCB_JUMP_IF_WRAP_SET:        return f[2];
			default:                     return !f[4];
		endcase
	endfunction

	// One branch; hold keeps start up in the busy cycle with scrambled inputs, frz stalls the clock enable
	task automatic run(input fcb_cond_t c, input logic [4:0] f, input logic [6:0] k, input logic [15:0] pc,
			input logic hold, input int frz);
		logic        tk;
		logic [15:0] npc;
		int          n;
		tk = exp_take(c, f);
		npc = tk ? pc + 16'($signed(k)) + FCB_PC_STEP : pc + FCB_PC_STEP;
		@(posedge i_sys_clk);
		i_start <= 1'h1;
		i_cond <= c;
		flg <= f;
		i_jump_offset <= k;
		i_pc <= pc;
		@(posedge i_sys_clk);
		i_start <= hold;
		i_pc <= ~pc;
		flg <= ~f;
		i_clk_en <= (frz == 0);
		n = 1;
		#1;
		check(16'(o_busy), 16'(tk));
		check(16'(o_done), 16'(!tk));
		while (o_done !== 1'h1 && n < 9) begin
			@(posedge i_sys_clk);
			i_start <= 1'h0;
			if (n == frz) i_clk_en <= 1'h1;
			n++;
			#1;
			if (o_done !== 1'h1) check(16'(o_busy), 16'h0001);
		end
		if (n >= 9) begin
			bad_count++;
			summarize();
		end
		check(16'(n), 16'(tk ? 2 + frz : 1));
		check(16'(o_taken), 16'(tk));
		check(o_next_pc - pc, tk ? 16'($signed(k)) + FCB_PC_STEP : FCB_PC_STEP);
		check(16'(o_taken), 16'(exp_take(c, f)));
		check(o_next_pc, npc);
		check(16'(o_busy), 16'h0000);
		@(posedge i_sys_clk);
		#1;
		check(16'(o_done), 16'h0000);
		check(o_next_pc, npc);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_conds;
		for (int c = 0; c < 12; c++) begin
			foreach (pats[p]) run(fcb_cond_t'(c), pats[p], 7'(c) * 7'h0B, 16'h1230 + 16'(c), 1'h0, 0);
		end
		$display("test_conds done");
	endtask

	// Most negative offset, minus one and a wrap past the top of the address space
	task automatic test_offsets;
		run(FCB_JUMP_IF_NEGATIVE, 5'h08, 7'h40, 16'h0010, 1'h0, 0);
		run(FCB_JUMP_IF_SPARE_SET, 5'h01, 7'h7F, 16'h4000, 1'h0, 0);
		run(FCB_JUMP_IF_SPARE_SET, 5'h01, 7'h3F, 16'hFFFF, 1'h0, 0);
		$display("test_offsets done");
	endtask

	task automatic test_refuse_and_stall;
		run(FCB_JUMP_IF_WRAP_SET, 5'h04, 7'h05, 16'h2000, 1'h1, 0);
		run(FCB_JUMP_IF_SIGNED_LT, 5'h08, 7'h10, 16'h3000, 1'h0, 3);
		$display("test_refuse_and_stall done");
	endtask

	// Untaken branches on consecutive enabled edges, each answered on the next edge
	task automatic test_back_to_back;
		@(posedge i_sys_clk);
		i_start <= 1'h1;
		i_cond <= FCB_JUMP_IF_SPARE_SET;
		flg <= 5'h00;
		i_pc <= 16'h0100;
		@(posedge i_sys_clk);
		i_pc <= 16'h0200;
		#1;
		check(16'(o_done), 16'h0001);
		check(o_next_pc, 16'h0101);
		@(posedge i_sys_clk);
		i_start <= 1'h0;
		#1;
		check(16'(o_done), 16'h0001);
		check(o_next_pc, 16'h0201);
		@(posedge i_sys_clk);
		#1;
		check(16'(o_done), 16'h0000);
		$display("test_back_to_back done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge i_sys_clk);
		i_reset_n <= 1'h1;
		#1;
		check(o_next_pc, FCB_PC_RESET);
		check(16'(o_done), 16'h0000);
		test_conds();
		test_offsets();
		test_refuse_and_stall();
		test_back_to_back();
		summarize();
	end
endmodule
